/* File: design/sfm_pkg.sv */
// Shared constants and carrier types for the sink fault monitor.
// Assumes one 200 MHz clock and measurements already scaled to mV, mA and ohms.
package sfm_pkg;
  // Register command codes
  localparam logic [7:0] SFM_ADDR_STATUS = 8'h1D;
  localparam logic [7:0] SFM_ADDR_MASK   = 8'h1E;
  localparam logic [7:0] SFM_ADDR_TEMP   = 8'h22;
  localparam logic [7:0] SFM_ADDR_CURLIM = 8'h23;
  localparam logic [7:0] SFM_ADDR_OTLIM  = 8'h24;
  localparam logic [7:0] SFM_ADDR_DRLIM  = 8'h25;
  localparam logic [7:0] SFM_ADDR_THERMISTOR_OHMS_AT_25C   = 8'h28;
  localparam logic [7:0] SFM_ADDR_THERMISTOR_OHMS_AT_50C   = 8'h2A;
  localparam logic [7:0] SFM_ADDR_THERMISTOR_OHMS_AT_75C   = 8'h2C;
  localparam logic [7:0] SFM_ADDR_THERMISTOR_OHMS_AT_100C  = 8'h2E;
  // Status and mask bit positions
  localparam int SFM_BIT_READY   = 0;
  localparam int SFM_BIT_SUCCESS = 1;
  localparam int SFM_BIT_NEWSRC  = 2;
  localparam int SFM_BIT_OV      = 4;
  localparam int SFM_BIT_OC      = 5;
  localparam int SFM_BIT_OT      = 6;
  localparam int SFM_BIT_DR      = 7;
  // Reset values
  localparam logic [7:0]  SFM_RST_MASK   = 8'h01;
  localparam logic [7:0]  SFM_RST_TEMP   = 8'h19;
  localparam logic [7:0]  SFM_RST_CURLIM = 8'h00;
  localparam logic [7:0]  SFM_RST_OTLIM  = 8'h78;
  localparam logic [7:0]  SFM_RST_DRLIM  = 8'h78;
  localparam logic [15:0] SFM_RST_THERMISTOR_OHMS_AT_25C   = 16'h2710;
  localparam logic [15:0] SFM_RST_THERMISTOR_OHMS_AT_50C   = 16'h1041;
  localparam logic [15:0] SFM_RST_THERMISTOR_OHMS_AT_75C   = 16'h0788;
  localparam logic [15:0] SFM_RST_THERMISTOR_OHMS_AT_100C  = 16'h03CE;
  // Scaling and limits
  localparam logic [17:0] SFM_OV_SPLIT_MV   = 18'h0_4650;  // 18000 mV
  localparam logic [17:0] SFM_OV_OFFSET_MV  = 18'h0_07D0;  // 2000 mV
  localparam logic [15:0] SFM_CURLIM_LSB_MA = 16'h0032;    // 50 mA
  localparam logic [8:0]  SFM_RECOVER_DEGC  = 9'h00A;      // 10 degC
  // Timing
  localparam int SFM_CLK_MHZ      = 200;
  localparam int SFM_DEBOUNCE_MS  = 30;
  localparam int SFM_DEBOUNCE_CYC = SFM_DEBOUNCE_MS * 1000 * SFM_CLK_MHZ;

  // Measurements from the sense front end
  typedef struct packed {
    logic [15:0] vbus_mv;
    logic [15:0] ibus_ma;
    logic [15:0] ntc_ohms;
  } sfm_meas_t;

  // Current contract from the negotiation engine
  typedef struct packed {
    logic [15:0] negotiated_voltage;    // mV
    logic [15:0] contract_max_current;  // mA
    logic        pps;
  } sfm_contract_t;

  // Decoded register access from the serial front end
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } sfm_reg_req_t;
endpackage

/* File: design/sfm_monitor.sv */
// Fault supervision, temperature estimate and alert line of a PD sink.
// Assumes the serial front end delivers decoded one-cycle register accesses
// and that measurements and negotiation events arrive on sys_clk.
// Functional notes
// - Single level alert output on fault pin
// - Alert high for enabled events only
// - Mask 0x11 alerts on overvoltage
// - Overvoltage level: plus 2 V, else 110%
// - Status bit 4 after 30 ms overvoltage
// - Any debounced fault opens power switch
// - Zero limit uses 110% contract current
// - Nonzero limit uses 110% of setting
// - Status bit 5 after 30 ms overcurrent
// - Status bit 6 after 30 ms overheat
// - Programmable contract derates to half current
// - Restore full current more than 10 degC below derate
// - Interpolate temperature inside calibrated range
// - Extrapolate above 25 degree resistance
// - Extrapolate below 100 degree resistance
// - Calibration registers reset to defaults
// - Mask bit layout B7 derate..B0 ready
// - Current limit setting is 50 mA per bit
// - Temperature register whole degC, resets 19h
`timescale 1ns/1ps
`default_nettype none
module sfm_monitor
  import sfm_pkg::*;
#(
  parameter int DEBOUNCE_CYCLES = SFM_DEBOUNCE_CYC
) (
  input  wire  logic          sys_clk,
  input  wire  logic          reset,
  input  wire  sfm_meas_t     meas,
  input  wire  sfm_contract_t contract,
  input  wire  logic          ev_ready,
  input  wire  logic          ev_success,
  input  wire  logic          ev_new_source,
  input  wire  sfm_reg_req_t  reg_req,
  output logic [15:0]         reg_rdata,
  output logic                fault_alert_pin,
  output logic                power_switch_on,
  output logic                half_current_request
);
  localparam int CW = $clog2(DEBOUNCE_CYCLES + 1);
  localparam logic [CW-1:0] DBC_LAST = CW'(DEBOUNCE_CYCLES - 1);

  // Refuse a debounce period that cannot be counted
  if (DEBOUNCE_CYCLES < 2) begin : g_chk
    $error("DEBOUNCE_CYCLES must be at least 2");
  end

  // 110% of a value, truncated to whole units
  function automatic logic [17:0] pct110(input logic [17:0] x);
    return x + x / 18'd10;
  endfunction

  // Temperature from resistance by straight line through a calibration pair
  function automatic logic [7:0] temp_est(input logic [15:0] r, input logic [15:0] c25,
                                          input logic [15:0] c50, input logic [15:0] c75,
                                          input logic [15:0] c100);
    int ra;
    int rb;
    int ta;
    int den;
    int t;
    if (r > c50) begin
      ra = int'(c25);
      rb = int'(c50);
      ta = 25;
    end else if (r > c75) begin
      ra = int'(c50);
      rb = int'(c75);
      ta = 50;
    end else begin
      ra = int'(c75);
      rb = int'(c100);
      ta = 75;
    end
    den = (ra > rb) ? (ra - rb) : 1;
    t = ta + ((ra - int'(r)) * 25) / den;
    if (t < 0) t = 0;
    if (t > 255) t = 255;
    return t[7:0];
  endfunction

  // Registers
  logic [7:0]    mask_ff, status_ff, temp_ff, curlim_ff, otlim_ff, drlim_ff;
  logic [15:0]   thermistor_ohms_at_25c_ff, thermistor_ohms_at_50c_ff, thermistor_ohms_at_75c_ff, thermistor_ohms_at_100c_ff, rdata_ff;
  logic          alert_ff, power_ff, contract_ok_ff, derate_ff;
  logic [CW-1:0] dbc_cnt_ff [4];

  // Access decode
  wire wr_mask   = reg_req.wr && reg_req.addr == SFM_ADDR_MASK;
  wire wr_curlim = reg_req.wr && reg_req.addr == SFM_ADDR_CURLIM;
  wire wr_otlim  = reg_req.wr && reg_req.addr == SFM_ADDR_OTLIM;
  wire wr_drlim  = reg_req.wr && reg_req.addr == SFM_ADDR_DRLIM;
  wire wr_thermistor_ohms_at_25c   = reg_req.wr && reg_req.addr == SFM_ADDR_THERMISTOR_OHMS_AT_25C;
  wire wr_thermistor_ohms_at_50c   = reg_req.wr && reg_req.addr == SFM_ADDR_THERMISTOR_OHMS_AT_50C;
  wire wr_thermistor_ohms_at_75c   = reg_req.wr && reg_req.addr == SFM_ADDR_THERMISTOR_OHMS_AT_75C;
  wire wr_thermistor_ohms_at_100c  = reg_req.wr && reg_req.addr == SFM_ADDR_THERMISTOR_OHMS_AT_100C;
  wire rd_status = reg_req.rd && reg_req.addr == SFM_ADDR_STATUS;

  // Overvoltage trip level from the contract voltage
  wire [17:0] negotiated_voltage_mv = {2'b00, contract.negotiated_voltage};
  wire [17:0] ov_level = (negotiated_voltage_mv <= SFM_OV_SPLIT_MV) ? negotiated_voltage_mv + SFM_OV_OFFSET_MV
                                                       : pct110(negotiated_voltage_mv);
  // Overcurrent trip level: setting if nonzero, else contract current
  wire [17:0] curlim_ma = 18'(curlim_ff * SFM_CURLIM_LSB_MA);
  wire [17:0] contract_max_current_ma   = {2'b00, contract.contract_max_current};
  wire [17:0] oc_level  = (curlim_ff != 8'h00) ? pct110(curlim_ma)
                                               : pct110(contract_max_current_ma);

  // Raw comparisons feeding the debouncers, index order ov, oc, ot, dr
  wire [8:0] temp_plus = {1'b0, temp_ff} + SFM_RECOVER_DEGC;
  wire [3:0] cond;
  assign cond[0] = {2'b00, meas.vbus_mv} > ov_level;
  assign cond[1] = contract_ok_ff && ({2'b00, meas.ibus_ma} > oc_level);
  assign cond[2] = temp_ff > otlim_ff;
  assign cond[3] = contract.pps && contract_ok_ff && !derate_ff
                   && temp_ff > drlim_ff;
  wire recover   = derate_ff && temp_plus < {1'b0, drlim_ff};

  // Debounce completions
  wire [3:0] hit;
  assign hit[0] = cond[0] && dbc_cnt_ff[0] == DBC_LAST;
  assign hit[1] = cond[1] && dbc_cnt_ff[1] == DBC_LAST;
  assign hit[2] = cond[2] && dbc_cnt_ff[2] == DBC_LAST;
  assign hit[3] = cond[3] && dbc_cnt_ff[3] == DBC_LAST;
  wire fault_hit = |hit[2:0];

  // Status: hardware sets win over the read clear
  wire [7:0] status_set = {hit[3], hit[2], hit[1], hit[0], 1'b0,
                           ev_new_source, ev_success, ev_ready};
  wire [7:0] nxt_status = (rd_status ? 8'h00 : status_ff) | status_set;
  wire       nxt_alert  = |(nxt_status & mask_ff);

  // Read mux
  logic [15:0] nxt_rdata;
  always_comb begin
    unique case (reg_req.addr)
      SFM_ADDR_STATUS: nxt_rdata = {8'h00, status_ff};
      SFM_ADDR_MASK:   nxt_rdata = {8'h00, mask_ff};
      SFM_ADDR_TEMP:   nxt_rdata = {8'h00, temp_ff};
      SFM_ADDR_CURLIM: nxt_rdata = {8'h00, curlim_ff};
      SFM_ADDR_OTLIM:  nxt_rdata = {8'h00, otlim_ff};
      SFM_ADDR_DRLIM:  nxt_rdata = {8'h00, drlim_ff};
      SFM_ADDR_THERMISTOR_OHMS_AT_25C:   nxt_rdata = thermistor_ohms_at_25c_ff;
      SFM_ADDR_THERMISTOR_OHMS_AT_50C:   nxt_rdata = thermistor_ohms_at_50c_ff;
      SFM_ADDR_THERMISTOR_OHMS_AT_75C:   nxt_rdata = thermistor_ohms_at_75c_ff;
      SFM_ADDR_THERMISTOR_OHMS_AT_100C:  nxt_rdata = thermistor_ohms_at_100c_ff;
      default:         nxt_rdata = 16'h0000;
    endcase
  end

  // Host writable settings
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      mask_ff   <= SFM_RST_MASK;
      curlim_ff <= SFM_RST_CURLIM;
      otlim_ff  <= SFM_RST_OTLIM;
      drlim_ff  <= SFM_RST_DRLIM;
      thermistor_ohms_at_25c_ff   <= SFM_RST_THERMISTOR_OHMS_AT_25C;
      thermistor_ohms_at_50c_ff   <= SFM_RST_THERMISTOR_OHMS_AT_50C;
      thermistor_ohms_at_75c_ff   <= SFM_RST_THERMISTOR_OHMS_AT_75C;
      thermistor_ohms_at_100c_ff  <= SFM_RST_THERMISTOR_OHMS_AT_100C;
    end else begin
      if (wr_mask)   mask_ff   <= reg_req.wdata[7:0];
      if (wr_curlim) curlim_ff <= reg_req.wdata[7:0];
      if (wr_otlim)  otlim_ff  <= reg_req.wdata[7:0];
      if (wr_drlim)  drlim_ff  <= reg_req.wdata[7:0];
      if (wr_thermistor_ohms_at_25c)   thermistor_ohms_at_25c_ff   <= reg_req.wdata;
      if (wr_thermistor_ohms_at_50c)   thermistor_ohms_at_50c_ff   <= reg_req.wdata;
      if (wr_thermistor_ohms_at_75c)   thermistor_ohms_at_75c_ff   <= reg_req.wdata;
      if (wr_thermistor_ohms_at_100c)  thermistor_ohms_at_100c_ff  <= reg_req.wdata;
    end
  end

  // Debounce counters restart whenever their condition drops
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < 4; i++) dbc_cnt_ff[i] <= '0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (!cond[i] || hit[i]) dbc_cnt_ff[i] <= '0;
        else dbc_cnt_ff[i] <= dbc_cnt_ff[i] + 1'b1;
      end
    end
  end

  // Status, estimate, alert and read data
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      status_ff <= 8'h00;
      temp_ff   <= SFM_RST_TEMP;
      alert_ff  <= 1'b0;
      rdata_ff  <= 16'h0000;
    end else begin
      status_ff <= nxt_status;
      temp_ff   <= temp_est(meas.ntc_ohms, thermistor_ohms_at_25c_ff, thermistor_ohms_at_50c_ff, thermistor_ohms_at_75c_ff, thermistor_ohms_at_100c_ff);
      alert_ff  <= nxt_alert;
      rdata_ff  <= reg_req.rd ? nxt_rdata : rdata_ff;
    end
  end

  // Power path and contract tracking; a fault beats a new success
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      power_ff       <= 1'b0;
      contract_ok_ff <= 1'b0;
      derate_ff      <= 1'b0;
    end else begin
      if (fault_hit) begin
        power_ff       <= 1'b0;
        contract_ok_ff <= 1'b0;
        derate_ff      <= 1'b0;
      end else if (ev_success) begin
        power_ff       <= 1'b1;
        contract_ok_ff <= 1'b1;
        derate_ff      <= 1'b0;
      end else if (hit[3]) begin
        derate_ff      <= 1'b1;
      end else if (recover) begin
        derate_ff      <= 1'b0;
      end
    end
  end

  assign reg_rdata            = rdata_ff;
  assign fault_alert_pin      = alert_ff;
  assign power_switch_on      = power_ff;
  assign half_current_request = derate_ff;

  // Checks
  property p_alert_follows;
    @(posedge sys_clk) disable iff (reset)
      (|(nxt_status & mask_ff)) |=> fault_alert_pin;
  endproperty
  a_alert_follows: assert property (p_alert_follows) else $error("alert missed");

  property p_alert_drops;
    @(posedge sys_clk) disable iff (reset)
      !fault_alert_pin |-> !(|(status_ff & $past(mask_ff)));
  endproperty
  a_alert_drops: assert property (p_alert_drops) else $error("alert dropped early");

  property p_ov_mask;
    @(posedge sys_clk) disable iff (reset)
      (mask_ff == 8'h11 && hit[0]) |=> fault_alert_pin && status_ff[SFM_BIT_OV];
  endproperty
  a_ov_mask: assert property (p_ov_mask) else $error("overvoltage not alerted");

  property p_ov_cause;
    @(posedge sys_clk) disable iff (reset)
      $rose(status_ff[SFM_BIT_OV]) |-> $past(hit[0]) && $past(cond[0]);
  endproperty
  a_ov_cause: assert property (p_ov_cause) else $error("overvoltage bit uncaused");

  property p_fault_off;
    @(posedge sys_clk) disable iff (reset)
      fault_hit |=> !power_switch_on ##1 (!power_switch_on || $past(ev_success));
  endproperty
  a_fault_off: assert property (p_fault_off) else $error("switch left on");

  property p_oc_cause;
    @(posedge sys_clk) disable iff (reset)
      $rose(status_ff[SFM_BIT_OC]) |-> $past(hit[1]);
  endproperty
  a_oc_cause: assert property (p_oc_cause) else $error("overcurrent bit uncaused");

  property p_ot_cause;
    @(posedge sys_clk) disable iff (reset)
      $rose(status_ff[SFM_BIT_OT]) |-> $past(temp_ff > otlim_ff);
  endproperty
  a_ot_cause: assert property (p_ot_cause) else $error("overheat bit uncaused");

  property p_dr_pps;
    @(posedge sys_clk) disable iff (reset)
      $rose(half_current_request) |-> $past(contract.pps) && status_ff[SFM_BIT_DR];
  endproperty
  a_dr_pps: assert property (p_dr_pps) else $error("derate without pps");

  property p_recover;
    @(posedge sys_clk) disable iff (reset)
      (recover && !fault_hit && !ev_success) |=> !half_current_request;
  endproperty
  a_recover: assert property (p_recover) else $error("power not restored");

  property p_restart;
    @(posedge sys_clk) disable iff (reset)
      !cond[0] |=> dbc_cnt_ff[0] == '0;
  endproperty
  a_restart: assert property (p_restart) else $error("debounce not restarted");

  property p_no_oc_early;
    @(posedge sys_clk) disable iff (reset)
      !contract_ok_ff |=> !$rose(status_ff[SFM_BIT_OC]);
  endproperty
  a_no_oc_early: assert property (p_no_oc_early) else $error("trip before contract");

  c_ov:     cover property (@(posedge sys_clk) disable iff (reset) $rose(status_ff[SFM_BIT_OV]));
  c_derate: cover property (@(posedge sys_clk) disable iff (reset) $rose(half_current_request));
  c_restor: cover property (@(posedge sys_clk) disable iff (reset) $fell(half_current_request));
  c_alert:  cover property (@(posedge sys_clk) disable iff (reset) $rose(fault_alert_pin));
endmodule // sfm_monitor
`default_nettype wire

/* File: sim/sfm_host_model.sv */
// Host controller model: register accesses, calibration load and renegotiation.
// Assumes it is called only after reset is released, one access at a time.
`timescale 1ns/1ps
`default_nettype none
module sfm_host_model
  import sfm_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        fault_alert_pin,
  input  wire logic [15:0] reg_rdata,
  output var sfm_reg_req_t reg_req,
  output var logic         neg_done
);
  int alerts;
  initial begin
    reg_req = '0;
    neg_done = 1'b0;
    alerts = 0;
  end
  // Counts alert rises the host would service
  always @(posedge fault_alert_pin) alerts++;
  // Released bus lines do not keep the last value
  task automatic release_bus();
    reg_req.wr <= 1'b0;
    reg_req.rd <= 1'b0;
    reg_req.addr <= ~reg_req.addr;
    reg_req.wdata <= ~reg_req.wdata;
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk);
    release_bus();
  endtask
  task automatic reg_read(input logic [7:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: reg_req.wdata};
    @(posedge sys_clk);
    release_bus();
    @(posedge sys_clk);
    #1 d = reg_rdata;
  endtask
  // Mask first, then the four calibration points, before any temperature use
  task automatic init_host();
    reg_write(SFM_ADDR_MASK, 16'h0011);
    reg_write(SFM_ADDR_THERMISTOR_OHMS_AT_25C, 16'h2710);
    reg_write(SFM_ADDR_THERMISTOR_OHMS_AT_50C, 16'h1041);
    reg_write(SFM_ADDR_THERMISTOR_OHMS_AT_75C, 16'h0788);
    reg_write(SFM_ADDR_THERMISTOR_OHMS_AT_100C, 16'h03CE);
  endtask
  // Fresh request after a shutdown, answered by a success pulse
  task automatic renegotiate();
    @(posedge sys_clk);
    neg_done <= 1'b1;
    @(posedge sys_clk);
    neg_done <= 1'b0;
  endtask
endmodule  // sfm_host_model
`default_nettype wire

/* File: sim/sink_fault_monitor_irq_test.sv */
// Self-checking bench of the sink fault monitor with a host model.
// Assumes a short debounce parameter; expectations come from the limits.
`timescale 1ns/1ps
`default_nettype none
module sink_fault_monitor_irq_test;
  import sfm_pkg::*;
  localparam int DEB = 16;
  typedef struct packed {
    logic [15:0] ntc;
    logic [7:0]  addr;
    logic [15:0] exp;
  } sfm_row_t;
  logic          sys_clk;
  logic          reset;
  sfm_meas_t     meas;
  sfm_contract_t contract;
  sfm_reg_req_t  reg_req;
  logic [15:0]   reg_rdata;
  logic          fault_alert_pin;
  logic          power_switch_on;
  logic          half_current_request;
  logic          neg_done;
  logic [15:0]   d;
  int            err_total = 0;
  int            n_tests = 0;
  // Table rows: thermistor input, register, expected read value
  localparam sfm_row_t ROWS [12] = '{
    '{16'h2710, SFM_ADDR_MASK, 16'h0011},
    '{16'h2710, SFM_ADDR_OTLIM, 16'h0078},
    '{16'h2710, SFM_ADDR_THERMISTOR_OHMS_AT_25C, 16'h2710},
    '{16'h2710, SFM_ADDR_THERMISTOR_OHMS_AT_50C, 16'h1041},
    '{16'h2710, SFM_ADDR_THERMISTOR_OHMS_AT_75C, 16'h0788},
    '{16'h2710, SFM_ADDR_THERMISTOR_OHMS_AT_100C, 16'h03CE},
    '{16'h2710, SFM_ADDR_TEMP, 16'h0019},
    '{16'h2710, 8'h30, 16'h0000},  // Unmapped code reads zero
    '{16'h08CA, SFM_ADDR_TEMP, 16'h0047},
    '{16'h054B, SFM_ADDR_TEMP, 16'h005A},
    '{16'h3DDF, SFM_ADDR_TEMP, 16'h0000},
    '{16'h0014, SFM_ADDR_TEMP, 16'h007D}
  };
  sfm_monitor #(.DEBOUNCE_CYCLES(DEB)) i_dut (
    .sys_clk(sys_clk), .reset(reset), .meas(meas), .contract(contract),
    .ev_ready(neg_done), .ev_success(neg_done), .ev_new_source(neg_done),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .fault_alert_pin(fault_alert_pin),
    .power_switch_on(power_switch_on), .half_current_request(half_current_request));
  sfm_host_model i_host (
    .sys_clk(sys_clk), .fault_alert_pin(fault_alert_pin), .reg_rdata(reg_rdata),
    .reg_req(reg_req), .neg_done(neg_done));
  // 200 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chkb(input string nm, input logic e, input logic g);
    chk(nm, {15'h0000, e}, {15'h0000, g});
  endtask
  // Reads status, which also clears it, and checks one bit
  task automatic st_bit(input string nm, input int b, input logic e);
    i_host.reg_read(SFM_ADDR_STATUS, d);
    chkb(nm, e, d[b]);
  endtask
  // Applies measurements and holds them past the debounce span
  task automatic dwell(input logic [15:0] v, input logic [15:0] i, input logic [15:0] r);
    @(posedge sys_clk);
    meas <= '{vbus_mv: v, ibus_ma: i, ntc_ohms: r};
    repeat (DEB + 4) @(posedge sys_clk);
    #1;
  endtask
  task automatic reneg();
    i_host.renegotiate();
    i_host.reg_read(SFM_ADDR_STATUS, d);
  endtask
  task automatic finish_test();
    $display("Comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    finish_test();
  end
  initial begin
    reset = 1'b1;
    meas = '{vbus_mv: 16'h3A98, ibus_ma: 16'h03E8, ntc_ohms: 16'h2710};
    contract = '{negotiated_voltage: 16'h3A98, contract_max_current: 16'h0BB8, pps: 1'b0};
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    i_host.init_host();
    for (int k = 0; k < 12; k++) begin
      @(posedge sys_clk);
      meas.ntc_ohms <= ROWS[k].ntc;
      repeat (3) @(posedge sys_clk);
      i_host.reg_read(ROWS[k].addr, d);
      chk("table read", ROWS[k].exp, d);
    end
    dwell(16'h3A98, 16'h03E8, 16'h2710);
    i_host.renegotiate();
    repeat (3) @(posedge sys_clk);
    chkb("alert ready", 1'b1, fault_alert_pin);
    st_bit("status ready", 0, 1'b1);
    chkb("status new source", 1'b1, d[SFM_BIT_NEWSRC]);
    chkb("power on", 1'b1, power_switch_on);
    // Overvoltage: broken run, boundary, then a real fault (15 V contract)
    @(posedge sys_clk) meas.vbus_mv <= 16'h4269;
    repeat (10) @(posedge sys_clk);
    meas.vbus_mv <= 16'h3A98;
    @(posedge sys_clk) meas.vbus_mv <= 16'h4269;
    repeat (10) @(posedge sys_clk);
    #1 chkb("power restart", 1'b1, power_switch_on);
    dwell(16'h4268, 16'h03E8, 16'h2710);
    chkb("power ov edge", 1'b1, power_switch_on);
    dwell(16'h4269, 16'h03E8, 16'h2710);
    chkb("power ov", 1'b0, power_switch_on);
    chkb("alert ov", 1'b1, fault_alert_pin);
    st_bit("status ov", 4, 1'b1);
    repeat (2) @(posedge sys_clk);
    chkb("alert cleared", 1'b0, fault_alert_pin);
    // Overvoltage at 19 V contract uses 110 percent, not plus 2 V
    contract.negotiated_voltage <= 16'h4A38;
    dwell(16'h4E20, 16'h03E8, 16'h2710);
    reneg();
    dwell(16'h51A4, 16'h03E8, 16'h2710);
    chkb("power ov110 edge", 1'b1, power_switch_on);
    dwell(16'h51A5, 16'h03E8, 16'h2710);
    chkb("power ov110", 1'b0, power_switch_on);
    // Overcurrent from contract current, masked from the alert
    dwell(16'h4E20, 16'h03E8, 16'h2710);
    reneg();
    dwell(16'h4E20, 16'h0CE4, 16'h2710);
    chkb("power oc edge", 1'b1, power_switch_on);
    dwell(16'h4E20, 16'h0CE5, 16'h2710);
    chkb("power oc", 1'b0, power_switch_on);
    chkb("alert masked", 1'b0, fault_alert_pin);
    st_bit("status oc", 5, 1'b1);
    dwell(16'h4E20, 16'h1388, 16'h2710);
    st_bit("oc without contract", 5, 1'b0);
    // Overcurrent from the written limit, 40 steps of 50 mA
    i_host.reg_write(SFM_ADDR_CURLIM, 16'h0028);
    dwell(16'h4E20, 16'h03E8, 16'h2710);
    reneg();
    dwell(16'h4E20, 16'h0898, 16'h2710);
    chkb("power lim edge", 1'b1, power_switch_on);
    dwell(16'h4E20, 16'h0899, 16'h2710);
    chkb("power lim", 1'b0, power_switch_on);
    // Derating and overheat with limits 60 and 80 degrees
    i_host.reg_write(SFM_ADDR_MASK, 16'h00C0);
    i_host.reg_write(SFM_ADDR_OTLIM, 16'h0050);
    i_host.reg_write(SFM_ADDR_DRLIM, 16'h003C);
    dwell(16'h4E20, 16'h03E8, 16'h2710);
    reneg();
    dwell(16'h4E20, 16'h03E8, 16'h08CA);
    chkb("no derate fixed", 1'b0, half_current_request);
    @(posedge sys_clk) contract.pps <= 1'b1;
    reneg();
    dwell(16'h4E20, 16'h03E8, 16'h08CA);
    chkb("derate", 1'b1, half_current_request);
    chkb("power derate", 1'b1, power_switch_on);
    chkb("alert derate", 1'b1, fault_alert_pin);
    st_bit("status derate", 7, 1'b1);
    dwell(16'h4E20, 16'h03E8, 16'h1041);
    chkb("derate held", 1'b1, half_current_request);
    dwell(16'h4E20, 16'h03E8, 16'h2280);
    chkb("derate ended", 1'b0, half_current_request);
    dwell(16'h4E20, 16'h03E8, 16'h054B);
    chkb("power ot", 1'b0, power_switch_on);
    st_bit("status ot", 6, 1'b1);
    // Reset in mid-run restores defaults
    @(posedge sys_clk) reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chkb("alert in reset", 1'b0, fault_alert_pin);
    chkb("power in reset", 1'b0, power_switch_on);
    chkb("alert counted", 1'b1, i_host.alerts > 0);
    reset <= 1'b0;
    i_host.reg_read(SFM_ADDR_MASK, d);
    chk("mask reset", 16'h0001, d);
    i_host.reg_read(SFM_ADDR_THERMISTOR_OHMS_AT_50C, d);
    chk("cal reset", 16'h1041, d);
    finish_test();
  end
endmodule  // sink_fault_monitor_irq_test
`default_nettype wire
